// ===== src/spiirc_pkg.sv
// Constants and types of the serial interrupt, reset and pin control block.
// Assumes a 32-bit AHB-Lite register bus; each register is one aligned word.
package spiirc_pkg;

    // Register byte offsets, decoded on the low address bits
    localparam int          ADDR_W   = 4;
    localparam logic [3:0]  OFS_CTRL = 4'h0;
    localparam logic [3:0]  OFS_STAT = 4'h4;
    localparam logic [3:0]  OFS_DATA = 4'h8;

    // Bit positions in the status/control register
    localparam int ST_RXF   = 7;
    localparam int ST_ERROR_IRQ_ENABLE = 6;
    localparam int ST_OVR   = 5;
    localparam int ST_SF    = 4;
    localparam int ST_TXE   = 3;
    localparam int ST_SFDE  = 2;
    localparam int ST_RHI   = 1;
    localparam int ST_RLO   = 0;

    // Control register layout
    typedef struct packed {
        logic rx_irq_enable;
        logic reserved_b6;
        logic master_select;
        logic cpol;
        logic cpha;
        logic wired_or_select;
        logic module_enable;
        logic tx_irq_enable;
    } spiirc_ctrl_type;

    // Master select and clock phase come out of reset set
    localparam spiirc_ctrl_type CTRL_RST = 8'h28;

    // The three serial pins that the block can drive
    typedef struct packed {
        logic sck;
        logic mosi;
        logic miso;
    } spiirc_pins_type;

    // Sixteen clock edges make one byte
    localparam logic [3:0] LAST_EDGE = 4'hF;

    // Master half-period in bus clocks for each rate selection
    localparam logic [7:0] HALF_DIV_0 = 8'h01;
    localparam logic [7:0] HALF_DIV_1 = 8'h04;
    localparam logic [7:0] HALF_DIV_2 = 8'h08;
    localparam logic [7:0] HALF_DIV_3 = 8'h10;

    typedef enum logic [0:0] {SPIIRC_IDLE, SPIIRC_XFER} spiirc_state_type;

endpackage

// ===== src/spiirc_top.sv
// Byte-wide serial interface control: flags, interrupt requests, resets,
// low-power and break behaviour, and pin direction for the serial pins.
// Assumes a single AHB-Lite master; pins arrive asynchronously.
//
// What this block does
// - Transmit request only when tx empty, tx interrupt enable and module enable.
// - Receive request when rx full and rx enable, whatever module enable is.
// - Error enable lets overrun and select fault drive the shared request.
// - Select fault never sets while its detection is disabled.
// - Status read seeing rx full, then data read, clears rx full.
// - Only a data register write clears tx empty.
// - Rx full sets when a finished byte enters the receive register.
// - Tx empty sets when the buffer moves into the shift register.
// - System reset returns all control bits and flags to reset values.
// - Enable low: tx empty held, transfer aborted, shifter cleared, pins to port.
// - Disabling keeps control bits and rx full, overrun, select fault flags.
// - Master select fault with detection enabled clears module enable.
// - In wait the block runs, registers are closed, requests wake the CPU.
// - Stop freezes the shift engine; reset out of stop aborts and resets.
// - Break with clear-enable 0 blocks flag clears; a pre-break first step still counts.
// - Break with clear-enable 1 allows clears that persist afterwards.
// - Data write in break with clear-enable 0 is ignored completely.
// - Wired-OR select makes the driven serial pins open drain.
// - MISO driven only as slave with select low; select high floats it.
// - Enabled block sets serial pin directions, overriding port direction.
// - Master drives the clock, slave takes it; eight cycles per byte.
// - Master shifts out MOSI while capturing MISO on the same cycles.
// - Select fault on select low as master, or high mid-transfer as slave.
// - Byte completing with receive register unread sets overrun and is lost.
//
// The AHB-Lite register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module spiirc_top
    import spiirc_pkg::*;
(
    // Clock and reset
    input  wire logic            hclk,
    input  wire logic            hresetn,
    // AHB-Lite slave
    input  wire logic            hsel,
    input  wire logic [31:0]     haddr,
    input  wire logic [1:0]      htrans,
    input  wire logic            hwrite,
    input  wire logic [2:0]      hsize,
    input  wire logic [31:0]     hwdata,
    input  wire logic            hready,
    output logic                 hreadyout,
    output logic                 hresp,
    output logic [31:0]          hrdata,
    // System integration unit
    input  wire logic            wait_mode,
    input  wire logic            stop_mode,
    input  wire logic            break_state,
    input  wire logic            break_clear_enable,
    output logic                 wake_req,
    // Interrupt requests
    output logic                 tx_irq,
    output logic                 rx_err_irq,
    // Shared port fallback when disabled
    input  wire spiirc_pins_type port_dout,
    input  wire spiirc_pins_type port_dir,
    // Serial pins, output enables active low
    input  wire logic            ss_n_in,
    input  wire spiirc_pins_type pin_in,
    output spiirc_pins_type      pin_out,
    output spiirc_pins_type      pin_oe_n
);

    // Bus access state
    logic                   act_q;
    logic                   act_wr_q;
    logic [ADDR_W-1:0]      act_addr_q;
    logic                   hreadyout_q;
    logic [31:0]            hrdata_q;
    // Registers and flags
    spiirc_ctrl_type        ctrl_q;
    logic                   error_irq_enable_q;
    logic                   sfde_q;
    logic [1:0]             rate_q;
    logic                   rxf_q;
    logic                   ovr_q;
    logic                   sf_q;
    logic                   txe_q;
    logic                   arm_rxf_q;
    logic                   arm_ovr_q;
    logic                   arm_sf_q;
    logic [7:0]             txbuf_q;
    logic [7:0]             rxd_q;
    // Engine
    spiirc_state_type       state_q;
    logic [7:0]             sh_q;
    logic                   out_q;
    logic [3:0]             edge_q;
    logic [7:0]             div_q;
    logic                   sck_lvl_q;
    logic                   done_q;
    // Pin synchronisers, order {ss, sck, mosi, miso}
    logic [3:0]             sync1_q;
    logic [3:0]             sync2_q;
    logic                   sck_prev_q;
    logic                   ss_prev_q;
    // Registered outputs
    logic                   tx_irq_q;
    logic                   rx_err_irq_q;
    logic                   wake_q;
    spiirc_pins_type        pin_out_q;
    spiirc_pins_type        pin_oe_n_q;

    logic ss_s, sck_s, mosi_s, miso_s;
    logic en, mst, protect, bus_ok;
    logic wr_ctrl, wr_stat, wr_data, rd_stat, rd_data;
    logic mfault, sfault, sel, sck_edge, ss_fall, tick;
    logic ev, sample, din, idle, start, load;
    logic [7:0] half_div;
    logic [7:0] rd_byte;
    spiirc_pins_type lvl, drv;

    assign {ss_s, sck_s, mosi_s, miso_s} = sync2_q;
    assign en      = ctrl_q.module_enable;
    assign mst     = ctrl_q.master_select;
    assign protect = break_state & ~break_clear_enable;
    assign bus_ok  = act_q & ~wait_mode;

    // Register access strobes in the data phase
    assign wr_ctrl = bus_ok & act_wr_q & (act_addr_q == OFS_CTRL);
    assign wr_stat = bus_ok & act_wr_q & (act_addr_q == OFS_STAT);
    assign wr_data = bus_ok & act_wr_q & (act_addr_q == OFS_DATA) & ~protect;
    assign rd_stat = bus_ok & ~act_wr_q & (act_addr_q == OFS_STAT);
    assign rd_data = bus_ok & ~act_wr_q & (act_addr_q == OFS_DATA);

    // Select faults exist only while detection is enabled
    assign mfault = en & mst & sfde_q & ~ss_s;
    assign sfault = en & ~mst & sfde_q & ss_s & (state_q == SPIIRC_XFER);

    // Engine event decode
    assign idle     = (state_q == SPIIRC_IDLE);
    assign sel      = en & ~mst & ~ss_s;
    assign sck_edge = sck_s ^ sck_prev_q;
    assign ss_fall  = sel & ss_prev_q;
    assign tick     = (div_q == 8'h00);
    assign ev       = ~idle & (mst ? tick : (sel & sck_edge));
    assign sample   = ev & (edge_q[0] == ctrl_q.cpha);
    assign din      = mst ? miso_s : mosi_s;
    assign start    = idle & en & ~stop_mode & (mst ? ~txe_q & ~wr_data
                      : (ctrl_q.cpha ? sck_edge & sel : ss_fall));
    assign load     = idle & en & ~stop_mode & ~txe_q & ~wr_data & (mst ? 1'b1 : sel);

    always_comb begin
        case (rate_q)
            2'b00:   half_div = HALF_DIV_0;
            2'b01:   half_div = HALF_DIV_1;
            2'b10:   half_div = HALF_DIV_2;
            default: half_div = HALF_DIV_3;
        endcase
    end

    // Two-flop synchronisers on every pin input
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_q    <= 4'hF;
            sync2_q    <= 4'hF;
            sck_prev_q <= 1'b0;
            ss_prev_q  <= 1'b1;
        end else begin
            sync1_q    <= {ss_n_in, pin_in.sck, pin_in.mosi, pin_in.miso};
            sync2_q    <= sync1_q;
            sck_prev_q <= sck_s;
            ss_prev_q  <= ss_s;
        end
    end

    // Bus slave: one wait state so writes land before any later read
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            act_q       <= 1'b0;
            act_wr_q    <= 1'b0;
            act_addr_q  <= '0;
            hreadyout_q <= 1'b1;
        end else if (act_q) begin
            act_q       <= 1'b0;
            hreadyout_q <= 1'b1;
        end else if (hsel && htrans[1] && hready) begin
            act_q       <= 1'b1;
            act_wr_q    <= hwrite;
            act_addr_q  <= haddr[ADDR_W-1:0];
            hreadyout_q <= 1'b0;
        end
    end

    // Read mux; unmapped addresses and wait mode read as zero
    always_comb begin
        case (act_addr_q)
            OFS_CTRL: rd_byte = ctrl_q;
            OFS_STAT: rd_byte = {rxf_q, error_irq_enable_q, ovr_q, sf_q, txe_q, sfde_q, rate_q};
            OFS_DATA: rd_byte = rxd_q;
            default:  rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (act_q && !act_wr_q) begin
            hrdata_q <= {24'h00_0000, bus_ok ? rd_byte : 8'h00};
        end
    end

    // Control register; a master select fault drops the enable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= CTRL_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= spiirc_ctrl_type'(hwdata[7:0]);
            end
            if (mfault) begin
                ctrl_q.module_enable <= 1'b0;
            end
        end
    end

    // Status control bits survive a disable
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            error_irq_enable_q <= 1'b0;
            sfde_q  <= 1'b0;
            rate_q  <= 2'b00;
        end else if (wr_stat) begin
            error_irq_enable_q <= hwdata[ST_ERROR_IRQ_ENABLE];
            sfde_q  <= hwdata[ST_SFDE];
            rate_q  <= {hwdata[ST_RHI], hwdata[ST_RLO]};
        end
    end

    // First step of each two-step clear; frozen while flags are protected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            arm_rxf_q <= 1'b0;
            arm_ovr_q <= 1'b0;
            arm_sf_q  <= 1'b0;
        end else if (!protect) begin
            if (rd_stat) begin
                arm_rxf_q <= rxf_q;
                arm_ovr_q <= ovr_q;
                arm_sf_q  <= sf_q;
            end
            if (rd_data) begin
                arm_rxf_q <= 1'b0;
                arm_ovr_q <= 1'b0;
            end
            if (wr_ctrl) begin
                arm_sf_q <= 1'b0;
            end
        end
    end

    // Receive flags: disable does not touch them, a set beats a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rxf_q <= 1'b0;
            ovr_q <= 1'b0;
            sf_q  <= 1'b0;
            rxd_q <= 8'h00;
        end else begin
            if (rd_data && arm_rxf_q && !protect) begin
                rxf_q <= 1'b0;
            end
            if (rd_data && arm_ovr_q && !protect) begin
                ovr_q <= 1'b0;
            end
            // Clear only when no fault condition is present right now
            if (wr_ctrl && arm_sf_q && !protect && !mfault && !sfault) begin
                sf_q <= 1'b0;
            end
            if (mfault || sfault) begin
                sf_q <= 1'b1;
            end
            if (done_q && rxf_q) begin
                ovr_q <= 1'b1;
            end else if (done_q && !ovr_q) begin
                rxf_q <= 1'b1;
                rxd_q <= sh_q;
            end
        end
    end

    // Transmit buffer and its empty flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            txe_q   <= 1'b1;
            txbuf_q <= 8'h00;
        end else begin
            if (wr_data) begin
                txe_q   <= 1'b0;
                txbuf_q <= hwdata[7:0];
            end
            if (load || !en) begin
                txe_q <= 1'b1;
            end
        end
    end

    // Shift engine; stop freezes it, disable aborts it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q   <= SPIIRC_IDLE;
            sh_q      <= 8'h00;
            out_q     <= 1'b0;
            edge_q    <= 4'h0;
            div_q     <= 8'h00;
            sck_lvl_q <= 1'b0;
            done_q    <= 1'b0;
        end else if (!en) begin
            state_q   <= SPIIRC_IDLE;
            sh_q      <= 8'h00;
            edge_q    <= 4'h0;
            sck_lvl_q <= ctrl_q.cpol;
            done_q    <= 1'b0;
        end else if (!stop_mode) begin
            done_q <= 1'b0;
            if (load) begin
                sh_q  <= txbuf_q;
                out_q <= txbuf_q[7];
            end
            if (idle) begin
                sck_lvl_q <= ctrl_q.cpol;
                div_q     <= half_div - 8'h01;
                edge_q    <= 4'h0;
                if (start) begin
                    state_q <= SPIIRC_XFER;
                end
            end else if (sfault || (!mst && ss_s)) begin
                state_q <= SPIIRC_IDLE;                        // Slave deselected: abort
            end else begin
                if (mst) begin
                    div_q <= tick ? half_div - 8'h01 : div_q - 8'h01;
                    if (tick) begin
                        sck_lvl_q <= ~sck_lvl_q;
                    end
                end
                if (sample) begin
                    sh_q <= {sh_q[6:0], din};
                end else if (ev) begin
                    out_q <= sh_q[7];
                end
                if (ev) begin
                    edge_q <= edge_q + 4'h1;
                    if (edge_q == LAST_EDGE) begin
                        state_q <= SPIIRC_IDLE;
                        done_q  <= 1'b1;
                    end
                end
            end
        end
    end

    // Pin levels and drive; enabled block overrides the port direction
    always_comb begin
        lvl = port_dout;
        drv = port_dir;
        if (en) begin
            lvl = '{sck: sck_lvl_q, mosi: out_q, miso: out_q};
            drv = '{sck: mst, mosi: mst, miso: ~mst & ~ss_s};
        end
    end

    // Open drain drives only lows; otherwise push-pull on the driven pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_out_q  <= '0;
            pin_oe_n_q <= '1;
        end else if (en && ctrl_q.wired_or_select) begin
            pin_out_q  <= '0;
            pin_oe_n_q <= ~drv | lvl;
        end else begin
            pin_out_q  <= lvl;
            pin_oe_n_q <= ~drv;
        end
    end

    // Level requests follow their flags; wake in wait on any request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tx_irq_q     <= 1'b0;
            rx_err_irq_q <= 1'b0;
            wake_q       <= 1'b0;
        end else begin
            tx_irq_q     <= txe_q & ctrl_q.tx_irq_enable & en;
            rx_err_irq_q <= (rxf_q & ctrl_q.rx_irq_enable)
                            | (error_irq_enable_q & (ovr_q | sf_q));
            wake_q       <= wait_mode & (tx_irq_q | rx_err_irq_q);
        end
    end

    assign hreadyout = hreadyout_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;
    assign tx_irq    = tx_irq_q;
    assign rx_err_irq = rx_err_irq_q;
    assign wake_req  = wake_q;
    assign pin_out   = pin_out_q;
    assign pin_oe_n  = pin_oe_n_q;

endmodule // spiirc_top

// ===== verification/spiirc_top_monitor.sv
// Port checks for the serial control block: bus timing, wake, pins.
// Assumes one clock domain and a single AHB-Lite master.
`timescale 1ns/1ps
module spiirc_top_monitor
    import spiirc_pkg::*;
(
    // Clock, reset and bus
    input wire logic            hclk,
    input wire logic            hresetn,
    input wire logic            hsel,
    input wire logic [1:0]      htrans,
    input wire logic            hwrite,
    input wire logic            hready,
    input wire logic            hreadyout,
    input wire logic [31:0]     hrdata,
    // System and requests
    input wire logic            wait_mode,
    input wire logic            stop_mode,
    input wire logic            wake_req,
    input wire logic            tx_irq,
    input wire logic            rx_err_irq,
    // Pins
    input wire spiirc_pins_type port_dout,
    input wire spiirc_pins_type port_dir,
    input wire logic            ss_n_in,
    input wire spiirc_pins_type pin_out,
    input wire spiirc_pins_type pin_oe_n
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Accepted transfer, its one wait state, and a read made in wait mode
    sequence take_s; hsel && htrans[1] && hready; endsequence
    sequence answer_s; !hreadyout ##1 hreadyout; endsequence
    sequence wait_read_s; take_s ##0 (!hwrite && wait_mode) ##1 wait_mode; endsequence

    bus_one_wait_a: assert property (take_s |=> answer_s)
        else $error("bus answer not after one wait state");
    wait_read_zero_a: assert property (wait_read_s |=> hrdata == 32'h0)
        else $error("read in wait mode returned data");
    wake_follow_a: assert property (wait_mode && (tx_irq || rx_err_irq) |=> wake_req)
        else $error("wake request missing");
    wake_drop_a: assert property (!wait_mode |=> !wake_req)
        else $error("wake request outside wait mode");
    stop_freeze_a: assert property (stop_mode [*3] |=> $stable(pin_out))
        else $error("pins moved in stop mode");
    reset_quiet_a: assert property ($rose(hresetn) |-> !tx_irq && !rx_err_irq && hreadyout)
        else $error("outputs not at reset values");
    port_fallback_a: assert property ($rose(hresetn) |=> pin_out == port_dout
        && pin_oe_n == spiirc_pins_type'(~port_dir))
        else $error("pins not under port control after reset");
    miso_release_a: assert property ((ss_n_in && !port_dir.miso) [*4] |-> pin_oe_n.miso)
        else $error("miso driven while deselected");
endmodule // spiirc_top_monitor

bind spiirc_top spiirc_top_monitor spiirc_top_monitor_i (.hclk, .hresetn, .hsel, .htrans,
    .hwrite, .hready, .hreadyout, .hrdata, .wait_mode, .stop_mode, .wake_req, .tx_irq,
    .rx_err_irq, .port_dout, .port_dir, .ss_n_in, .pin_out, .pin_oe_n);

// ===== verification/spiirc_far_end.sv
// Behavioural far end of the serial link: slave while the block masters,
// master with a 160 ns clock while the block is a slave.
// Assumes clock polarity 0, phase 0, MSB first.
`timescale 1ns/1ps
module spiirc_far_end (
    // Levels on the link
    input  wire logic sck_w,
    input  wire logic mosi_w,
    input  wire logic miso_w,
    // Driven by this model
    output logic      sck_o,
    output logic      mosi_o,
    output logic      miso_o,
    output logic      ss_n_o,
    output logic      is_master,
    // Last captured byte and byte count
    output logic [7:0] rx_byte,
    output int         nbytes
);
    logic [7:0] tx_sh;
    int         nbits;

    initial begin
        {sck_o, mosi_o, miso_o, ss_n_o, is_master} = 5'h0E;
        {rx_byte, tx_sh} = 16'h0;
        nbytes = 0;
        nbits = 0;
    end

    // Capture on the leading edge, eight bits make a byte
    always @(posedge sck_w) begin
        rx_byte = {rx_byte[6:0], is_master ? miso_w : mosi_w};
        nbits = (nbits == 7) ? 0 : nbits + 1;
        if (nbits == 0) nbytes = nbytes + 1;
    end

    // Next bit on the trailing edge; the freed low bit refills with the inverse of the old low bit so stale data never looks valid
    always @(negedge sck_w) begin
        tx_sh = {tx_sh[6:0], ~tx_sh[0]};
        if (is_master) mosi_o = tx_sh[7];
        else miso_o = tx_sh[7];
    end

    task automatic load(input logic [7:0] b);
        tx_sh = b;
        miso_o = b[7];
    endtask

    // One framed byte: select, eight clock cycles, deselect
    task automatic drive(input logic [7:0] b);
        // Step off the bus clock edge so the synchronisers never race the link
        #5;
        tx_sh = b;
        is_master = 1'b1;
        mosi_o = b[7];
        ss_n_o = 1'b0;
        #400;
        repeat (8) begin
            #80 sck_o = 1'b1;
            #80 sck_o = 1'b0;
        end
        #80 ss_n_o = 1'b1;
        is_master = 1'b0;
    endtask
endmodule // spiirc_far_end

// ===== verification/tb_top.sv
// Self-checking bench for the serial control block over AHB-Lite.
// Assumes the far-end model runs phase 0 framing at a 160 ns link clock.
`timescale 1ns/1ps
module tb_top;
    import spiirc_pkg::*;
    `define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin fails++; \
        $display("Error %0t: got %h expected %h", $time, a, e); end end

    logic            hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [31:0]     haddr = 0, hwdata = 0, hrdata;
    logic [1:0]      htrans = 0;
    logic [2:0]      hsize = 3'h2;
    logic            wait_mode = 0, stop_mode = 0, break_state = 0, break_clear_enable = 0;
    logic            wake_req, tx_irq, rx_err_irq, ss_tb_n = 1;
    logic            sck_o, mosi_o, miso_o, ss_n_o, is_master;
    logic [7:0]      rx_byte, rdv, b, s, rate;
    spiirc_pins_type port_dout = '0, port_dir = '0, pin_in, pin_out, pin_oe_n;
    int              fails = 0, checks_done = 0, nbytes, k;
    wire             ss_n_in = ss_n_o & ss_tb_n;

    // Wire levels: a driving party wins, else pull-up on data lines
    assign pin_in = {!pin_oe_n.sck ? pin_out.sck : sck_o,
                     !pin_oe_n.mosi ? pin_out.mosi : (is_master ? mosi_o : 1'b1),
                     !pin_oe_n.miso ? pin_out.miso : (is_master ? 1'b1 : miso_o)};

    spiirc_top spiirc_top_i (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
        .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .wait_mode, .stop_mode,
        .break_state, .break_clear_enable, .wake_req, .tx_irq, .rx_err_irq, .port_dout,
        .port_dir, .ss_n_in, .pin_in, .pin_out, .pin_oe_n);
    spiirc_far_end spiirc_far_end_i (.sck_w(pin_in.sck), .mosi_w(pin_in.mosi),
        .miso_w(pin_in.miso), .sck_o, .mosi_o, .miso_o, .ss_n_o, .is_master, .rx_byte, .nbytes);

    // 50 MHz bus clock
    always #10 hclk = ~hclk;

    function automatic logic [7:0] stat_exp(input logic rxf, ovr, sf, txe, input logic [7:0] cfg);
        return cfg | {rxf, 1'b0, ovr, sf, txe, 3'h0};
    endfunction

    task automatic summarize;
        if (fails == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    // Single word transfer; address held until taken, data until answered
    task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge hclk);
        {hsel, haddr, htrans, hwrite} <= {1'b1, 28'h0, a, 2'h2, w};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        {hsel, htrans, hwdata} <= {1'b0, 2'h0, 24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata[7:0];
    endtask

    task automatic rd(input logic [3:0] a); bus(1'b0, a, 8'h00); endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask
    task automatic poll(input int p); do rd(OFS_STAT); while (rdv[p] !== 1'b1); endtask

    task automatic xfer(input logic [7:0] bt, input logic [7:0] st);
        k = nbytes;
        spiirc_far_end_i.load(st);
        wr(OFS_DATA, bt);
        wait (nbytes == k + 1);
    endtask

    // Watchdog, well beyond the expected run
    initial begin
        #1_200_000;
        fails++;
        summarize;
    end

    // Main sequence
    initial begin
        void'($urandom(31440));
        rate = 8'($urandom_range(3, 2));
        port_dout = {1'b0, 2'($urandom)};
        port_dir = {2'($urandom), 1'b0};
        do_reset;
        rd(OFS_CTRL); `CHK(rdv, 8'(CTRL_RST))
        rd(OFS_STAT); `CHK(rdv, stat_exp(0, 0, 0, 1, 8'h00))
        `CHK(pin_out, port_dout)
        stop_mode <= 1'b1;
        repeat (10) @(posedge hclk);
        stop_mode <= 1'b0;
        wr(OFS_STAT, rate);
        wr(OFS_CTRL, 8'h23);
        repeat (3) @(posedge hclk);
        `CHK(tx_irq, 1'b1)
        // Exchanges with all-ones and all-zeros corners first
        for (int i = 0; i < 4; i++) begin
            b = (i == 0) ? 8'hFF : (i == 1) ? 8'h00 : 8'($urandom);
            s = (i == 0) ? 8'h00 : 8'($urandom);
            xfer(b, s);
            poll(ST_RXF);
            rd(OFS_DATA); `CHK(rdv, s)
            `CHK(rx_byte, b)
            rd(OFS_STAT); `CHK(rdv, stat_exp(0, 0, 0, 1, rate))
        end
        // Second byte arrives unread: old byte kept
        wr(OFS_STAT, rate | 8'h40);
        xfer(8'h3C, 8'h5A);
        poll(ST_RXF);
        xfer(8'hC3, 8'hA5);
        poll(ST_OVR); `CHK(rdv, stat_exp(1, 1, 0, 1, rate | 8'h40))
        repeat (2) @(posedge hclk);
        `CHK(rx_err_irq, 1'b1)
        rd(OFS_DATA); `CHK(rdv, 8'h5A)
        rd(OFS_STAT); `CHK(rdv, stat_exp(0, 0, 0, 1, rate | 8'h40))
        repeat (2) @(posedge hclk);
        `CHK(rx_err_irq, 1'b0)
        // Disable with a byte pending
        xfer(8'h81, 8'h7E);
        poll(ST_RXF);
        wr(OFS_CTRL, 8'hA0);
        repeat (3) @(posedge hclk);
        `CHK(rx_err_irq, 1'b1)
        `CHK(tx_irq, 1'b0)
        `CHK(pin_out, port_dout)
        rd(OFS_CTRL); `CHK(rdv, 8'hA0)
        rd(OFS_STAT); `CHK(rdv, stat_exp(1, 0, 0, 1, rate | 8'h40))
        // Protected break: write ignored, clear only completes after it
        wr(OFS_CTRL, 8'h23);
        break_state <= 1'b1;
        k = nbytes;
        wr(OFS_DATA, 8'h99);
        rd(OFS_DATA);
        rd(OFS_STAT); `CHK(rdv, stat_exp(1, 0, 0, 1, rate | 8'h40))
        repeat (40) @(posedge hclk);
        `CHK(nbytes, k)
        break_state <= 1'b0;
        rd(OFS_DATA);
        rd(OFS_STAT); `CHK(rdv[ST_RXF], 1'b0)
        xfer(8'h42, 8'hA4);
        poll(ST_RXF);
        {break_state, break_clear_enable} <= 2'h3;
        rd(OFS_STAT);
        rd(OFS_DATA);
        {break_state, break_clear_enable} <= 2'h0;
        rd(OFS_STAT); `CHK(rdv[ST_RXF], 1'b0)
        // Wait mode closes the registers but still wakes
        wait_mode <= 1'b1;
        rd(OFS_CTRL); `CHK(rdv, 8'h00)
        `CHK(wake_req, 1'b1)
        wait_mode <= 1'b0;
        // Open drain only ever pulls low, even with a high bit waiting
        wr(OFS_CTRL, 8'h27);
        repeat (3) @(posedge hclk);
        `CHK(pin_out, 3'h0)
        // Select low: ignored until detection is on, then a master fault
        ss_tb_n <= 1'b0;
        repeat (4) @(posedge hclk);
        rd(OFS_STAT); `CHK(rdv[ST_SF], 1'b0)
        wr(OFS_STAT, rate | 8'h44);
        do rd(OFS_CTRL); while (rdv[1] !== 1'b0);
        rd(OFS_STAT); `CHK(rdv, stat_exp(0, 0, 1, 1, rate | 8'h44))
        `CHK(rx_err_irq, 1'b1)
        ss_tb_n <= 1'b1;
        wr(OFS_STAT, rate);
        wr(OFS_CTRL, 8'h02);
        // Block as slave, far end clocks at 160 ns
        b = 8'($urandom);
        s = 8'($urandom);
        wr(OFS_DATA, b);
        fork
            spiirc_far_end_i.drive(s);
            begin #700; `CHK(pin_oe_n.miso, 1'b0) end
        join
        poll(ST_RXF);
        rd(OFS_DATA); `CHK(rdv, s)
        `CHK(rx_byte, b)
        do_reset;
        rd(OFS_CTRL); `CHK(rdv, 8'(CTRL_RST))
        summarize;
    end
endmodule // tb_top
